// File: axis_step_and_jog_mode_control_bench.sv
/*
 * bench of the axis step and jog mode controller: register tasks and
 * scripted step, abort, fault, interrupt and jog sequences.
 * assumes: the axis model beside it and the register map of the header.
 */
`include "axm_consts.svh"

module axis_step_and_jog_mode_control_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] c_step = 32'h1 << `AXM_CTRL_STEP_SEL;
    localparam logic [31:0] c_man = 32'h1 << `AXM_CTRL_MANUAL_SEL;
    localparam logic [31:0] c_drv = 32'h1 << `AXM_CTRL_DRIVE;
    localparam logic [31:0] c_rel = 32'h1 << `AXM_CTRL_REL;
    localparam logic [31:0] c_spd = 32'h1 << `AXM_CTRL_SPEED;
    localparam logic [31:0] c_stop = 32'h1 << `AXM_CTRL_STOP;
    localparam logic [31:0] c_ack = 32'h1 << `AXM_CTRL_ACK;
    localparam logic [31:0] c_go = 32'h1 << `AXM_CTRL_START;
    localparam logic [31:0] c_plus = 32'h1 << `AXM_CTRL_PLUS;
    localparam logic [31:0] c_minus = 32'h1 << `AXM_CTRL_MINUS;

    logic clock, rst, bus_wr, bus_rd, irq, motor_enable, motor_step, motor_dir;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata, bus_rdata, pos;
    logic [15:0] gap, g_creep;
    int err_count, cmp_count;

    // ==========================================================
    // design and axis model
    axm_top #(.CREEP_DIV(16'h0008), .RAPID_DIV(16'h0002)) DUT (
        .clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
        .motor_enable(motor_enable), .motor_step(motor_step), .motor_dir(motor_dir));
    axm_axis_model axis (
        .clock(clock), .rst(rst), .motor_enable(motor_enable),
        .motor_step(motor_step), .motor_dir(motor_dir), .pos(pos), .gap(gap));

    // ==========================================================
    // register access and comparison tasks
    task automatic final_report();
        if (err_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata; // data stand only in the cycle after the strobe
        @(posedge clock);
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d & m, e);
    endtask

    task automatic bit_chk(input logic [7:0] a, input int b, input logic v);
        chk_reg(a, 32'h1 << b, {31'h0, v} << b);
    endtask

    // status polling with a bound, a used-up bound ends the run
    task automatic wait_bit(input int b, input logic v);
        logic [31:0] d;
        int n;
        n = 0;
        rd(`AXM_ADDR_STATUS, d);
        while (d[b] !== v && n < 3000)
        begin
            rd(`AXM_ADDR_STATUS, d);
            n++;
        end
        chk({31'h0, d[b]}, {31'h0, v});
        if (n >= 3000)
            final_report();
    endtask

    // ==========================================================
    // clock
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        err_count = 0;
        cmp_count = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk_reg(`AXM_ADDR_STATUS, 32'h3F, 32'h0);
        chk_reg(`AXM_ADDR_IRQ_MASK, 32'h7, 32'h0);
        chk_reg(`AXM_ADDR_POSITION, 32'hFFFFFFFF, 32'h0);
        chk_reg(8'h20, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // dimensions loaded before any approach
        wr(`AXM_ADDR_DIM_INDEX, 32'h1);
        wr(`AXM_ADDR_DIM_VALUE, 32'h14);
        wr(`AXM_ADDR_DIM_INDEX, 32'h2);
        wr(`AXM_ADDR_DIM_VALUE, 32'h0C);
        wr(`AXM_ADDR_DIM_INDEX, 32'h3);
        wr(`AXM_ADDR_DIM_VALUE, 32'h190);
        wr(`AXM_ADDR_IRQ_MASK, 32'h1 << `AXM_IRQ_REACHED);
        // step mode, relative plus move of 20
        wr(`AXM_ADDR_CTRL, c_step | c_drv);
        chk_reg(`AXM_ADDR_STATUS, 32'h3, 32'h1);
        wr(`AXM_ADDR_TARGET, 32'h1); // valid index
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_rel | c_plus);
        bit_chk(`AXM_ADDR_STATUS, `AXM_STAT_MOTION, 1'b1);
        chk_reg(`AXM_ADDR_CTRL, c_go | c_plus | c_minus, 32'h0);
        wait_bit(`AXM_STAT_REACHED, 1'b1);
        bit_chk(`AXM_ADDR_STATUS, `AXM_STAT_MOTION, 1'b0);
        chk_reg(`AXM_ADDR_POSITION, 32'hFFFFFFFF, 32'h14);
        chk(pos, 32'h14);
        chk({31'h0, irq}, 32'h1);
        wr(`AXM_ADDR_IRQ_STATUS, 32'h1 << `AXM_IRQ_REACHED);
        chk({31'h0, irq}, 32'h0);
        // absolute move to 12, direction left to the controller
        wr(`AXM_ADDR_TARGET, 32'h2);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_go);
        bit_chk(`AXM_ADDR_STATUS, `AXM_STAT_REACHED, 1'b0);
        wait_bit(`AXM_STAT_REACHED, 1'b1);
        chk(pos, 32'h0C);
        // relative minus move of 20
        wr(`AXM_ADDR_TARGET, 32'h1);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_rel | c_minus);
        wait_bit(`AXM_STAT_REACHED, 1'b1);
        chk(pos, 32'hFFFFFFF8);
        chk_reg(`AXM_ADDR_POSITION, 32'hFFFFFFFF, 32'hFFFFFFF8);
        // long move aborted by stop, then by dropping the drive
        wr(`AXM_ADDR_TARGET, 32'h3);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_rel | c_plus);
        repeat (20) @(posedge clock);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_rel | c_stop);
        wait_bit(`AXM_STAT_MOTION, 1'b0);
        bit_chk(`AXM_ADDR_STATUS, `AXM_STAT_REACHED, 1'b0);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_rel | c_plus);
        repeat (20) @(posedge clock);
        wr(`AXM_ADDR_CTRL, c_step | c_rel);
        wait_bit(`AXM_STAT_MOTION, 1'b0);
        bit_chk(`AXM_ADDR_STATUS, `AXM_STAT_REACHED, 1'b0);
        bit_chk(`AXM_ADDR_STATUS, `AXM_STAT_FAULT, 1'b1);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_ack);
        // invalid index raises a fault, masked from the interrupt line
        wr(`AXM_ADDR_IRQ_STATUS, 32'h7);
        wr(`AXM_ADDR_TARGET, 32'h0);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_rel | c_plus);
        wait_bit(`AXM_STAT_FAULT, 1'b1);
        bit_chk(`AXM_ADDR_IRQ_STATUS, `AXM_IRQ_FAULT, 1'b1);
        chk({31'h0, irq}, 32'h0);
        wr(`AXM_ADDR_TARGET, 32'h1);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_rel | c_plus);
        repeat (10) @(posedge clock);
        bit_chk(`AXM_ADDR_STATUS, `AXM_STAT_MOTION, 1'b0);
        wr(`AXM_ADDR_CTRL, c_step | c_drv | c_ack);
        wait_bit(`AXM_STAT_FAULT, 1'b0);
        wr(`AXM_ADDR_CTRL, c_step | c_drv);
        // jog mode, creep then rapid, plus then minus
        wr(`AXM_ADDR_CTRL, c_man | c_drv);
        chk_reg(`AXM_ADDR_STATUS, 32'h3, 32'h2);
        wr(`AXM_ADDR_CTRL, c_man | c_drv | c_plus);
        wait_bit(`AXM_STAT_JOG_RUN, 1'b1);
        repeat (40) @(posedge clock);
        chk({31'h0, motor_dir}, 32'h1);
        g_creep = gap;
        wr(`AXM_ADDR_CTRL, c_man | c_drv | c_plus | c_spd);
        repeat (40) @(posedge clock);
        chk({31'h0, gap < g_creep}, 32'h1);
        chk_reg(`AXM_ADDR_CTRL, c_plus, c_plus);
        wr(`AXM_ADDR_CTRL, c_man | c_drv | c_stop);
        wait_bit(`AXM_STAT_JOG_RUN, 1'b0);
        wr(`AXM_ADDR_CTRL, c_man | c_drv | c_minus);
        repeat (40) @(posedge clock);
        chk({31'h0, motor_dir}, 32'h0);
        wr(`AXM_ADDR_CTRL, c_man | c_drv | c_stop);
        wait_bit(`AXM_STAT_JOG_RUN, 1'b0);
        chk_reg(`AXM_ADDR_POSITION, 32'hFFFFFFFF, pos);
        final_report();
    end
endmodule

// File: axm_axis_model.sv
/*
 * axis model: turns step pulses from the controller into a position and
 * measures the cycles between two steps.
 * assumes: one step per rising edge of motor_step while motor_enable is
 * high, motor_dir high means the positive direction.
 */
module axm_axis_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic motor_enable,
    input wire logic motor_step,
    input wire logic motor_dir,
    output logic [31:0] pos,
    output logic [15:0] gap
);
    timeunit 1ns;
    timeprecision 1ns;

    logic step_q;
    logic [15:0] since;

    // ==========================================================
    // position count and step spacing
    always_ff @(posedge clock)
    begin
        step_q <= motor_step;
        since <= since + 16'h0001;
        if (rst)
        begin
            pos <= 32'h0;
            gap <= 16'h0;
            since <= 16'h0;
        end
        else if (motor_step && !step_q && motor_enable)
        begin
            pos <= motor_dir ? pos + 32'h1 : pos - 32'h1; // a disabled drive ignores steps
            gap <= since;
            since <= 16'h0;
        end
    end
endmodule

// File: axm_consts.svh
/*
 * register offsets, field positions, reset values and counts of the axis
 * step and jog mode controller.
 * assumes: included by its bare name before any use of the macros.
 */
`ifndef AXM_CONSTS_SVH
`define AXM_CONSTS_SVH

// ==========================================================
// register byte offsets
`define AXM_ADDR_CTRL 8'h00
`define AXM_ADDR_TARGET 8'h04
`define AXM_ADDR_STATUS 8'h08
`define AXM_ADDR_POSITION 8'h0C
`define AXM_ADDR_DIM_INDEX 8'h10
`define AXM_ADDR_DIM_VALUE 8'h14
`define AXM_ADDR_IRQ_STATUS 8'h18
`define AXM_ADDR_IRQ_MASK 8'h1C

// ==========================================================
// control register fields
`define AXM_CTRL_STEP_SEL 0
`define AXM_CTRL_MANUAL_SEL 1
`define AXM_CTRL_DRIVE 2
`define AXM_CTRL_REL 3
`define AXM_CTRL_SPEED 4
`define AXM_CTRL_STOP 5
`define AXM_CTRL_ACK 6
`define AXM_CTRL_START 8
`define AXM_CTRL_PLUS 9
`define AXM_CTRL_MINUS 10
`define AXM_CTRL_RESET 11'h000

// ==========================================================
// status register fields
`define AXM_STAT_STEP_ACT 0
`define AXM_STAT_MANUAL_ACT 1
`define AXM_STAT_MOTION 2
`define AXM_STAT_REACHED 3
`define AXM_STAT_JOG_RUN 4
`define AXM_STAT_FAULT 5

// ==========================================================
// interrupt fields
`define AXM_IRQ_REACHED 0
`define AXM_IRQ_FAULT 1
`define AXM_IRQ_MOVE_END 2
`define AXM_IRQ_RESET 3'h0

// ==========================================================
// target indices and table slots
`define AXM_IDX_FIRST 8'h01
`define AXM_IDX_LAST 8'h64
`define AXM_IDX_SPECIAL_A 8'hFE
`define AXM_IDX_SPECIAL_B 8'hFF
`define AXM_SLOT_SPECIAL_A 7'h64
`define AXM_SLOT_SPECIAL_B 7'h65
`define AXM_TABLE_DEPTH 102

// ==========================================================
// step rate dividers in clock cycles
`define AXM_CREEP_DIV 16'h03E8
`define AXM_RAPID_DIV 16'h000A

`endif

// File: axm_motion.sv
/*
 * motion engine: steps the axis position at creep or rapid rate, either a
 * counted distance or continuously while jogging.
 * assumes: one clock, synchronous active high reset, halt wins over go.
 */
`include "axm_consts.svh"

module axm_motion #(
    parameter int POS_W = 32,
    parameter logic [15:0] CREEP_DIV = `AXM_CREEP_DIV,
    parameter logic [15:0] RAPID_DIV = `AXM_RAPID_DIV
) (
    input wire logic clock,
    input wire logic rst,
    axm_motion_if.eng mif,
    output logic step_pulse,
    output logic step_dir
);
    logic [15:0] div_reg;
    logic [15:0] div_limit;
    logic tick;
    logic busy_reg;
    logic arrived_reg;
    logic dir_reg;
    logic jog_reg;
    logic [POS_W-1:0] pos_reg;
    logic [POS_W-1:0] remain_reg;

    // ==========================================================
    // rate divider, one enable pulse per step period
    assign div_limit = mif.rapid ? RAPID_DIV : CREEP_DIV;
    assign tick = busy_reg && (div_reg >= div_limit - 16'h0001);

    always_ff @(posedge clock)
    begin
        if (rst || !busy_reg || tick)
            div_reg <= 16'h0000;
        else
            div_reg <= div_reg + 16'h0001;
    end

    // ==========================================================
    // move sequencing and position count
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            busy_reg <= 1'b0;
            arrived_reg <= 1'b0;
            dir_reg <= 1'b0;
            jog_reg <= 1'b0;
            pos_reg <= '0;
            remain_reg <= '0;
            step_pulse <= 1'b0;
        end
        else
        begin
            arrived_reg <= 1'b0;
            step_pulse <= 1'b0;
            if (mif.halt)
                busy_reg <= 1'b0; // abort, not arrived
            else if (mif.go)
            begin
                busy_reg <= 1'b1;
                dir_reg <= mif.dir_plus;
                jog_reg <= mif.jog;
                remain_reg <= mif.distance;
            end
            else if (tick)
            begin
                if (!jog_reg && remain_reg == '0)
                begin
                    busy_reg <= 1'b0;
                    arrived_reg <= 1'b1;
                end
                else
                begin
                    pos_reg <= dir_reg ? pos_reg + 1'b1 : pos_reg - 1'b1;
                    if (!jog_reg)
                        remain_reg <= remain_reg - 1'b1;
                    step_pulse <= 1'b1;
                end
            end
        end
    end

    assign step_dir = dir_reg;
    assign mif.busy = busy_reg;
    assign mif.arrived = arrived_reg;
    assign mif.position = pos_reg;
endmodule

// File: axm_motion_if.sv
/*
 * command and feedback signals between the mode controller and the
 * motion engine.
 * assumes: both ends run on the same clock.
 */
interface axm_motion_if #(parameter int POS_W = 32);
    logic go;
    logic dir_plus;
    logic jog;
    logic rapid;
    logic halt;
    logic [POS_W-1:0] distance;
    logic busy;
    logic arrived;
    logic [POS_W-1:0] position;

    // ==========================================================
    // controller and engine views
    modport ctl (output go, dir_plus, jog, rapid, halt, distance,
                 input busy, arrived, position);
    modport eng (input go, dir_plus, jog, rapid, halt, distance,
                 output busy, arrived, position);
endinterface

// File: axm_pkg.sv
/*
 * types shared by the axis step and jog mode controller.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package axm_pkg;
    // ==========================================================
    // operating mode selected by software
    typedef enum logic [1:0] {
        AXM_MODE_IDLE = 2'b00,
        AXM_MODE_STEP = 2'b01,
        AXM_MODE_JOG = 2'b10
    } axm_mode_type;
endpackage

// File: axm_top.sv
/*
 * axis step and jog mode controller: register port, mode selection,
 * command handshake, fault handling, target table and interrupts.
 * assumes: a single-cycle register master, inputs synchronous to clock.
 */
`include "axm_consts.svh"

module axm_top #(
    parameter int POS_W = 32,
    parameter logic [15:0] CREEP_DIV = `AXM_CREEP_DIV,
    parameter logic [15:0] RAPID_DIV = `AXM_RAPID_DIV
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    output logic irq,
    output logic motor_enable,
    output logic motor_step,
    output logic motor_dir
);
    axm_motion_if #(.POS_W(POS_W)) mif ();

    logic [10:0] ctrl_reg;
    logic [7:0] target_reg;
    logic [7:0] dim_index_reg;
    logic [POS_W-1:0] dim_reg [`AXM_TABLE_DEPTH];
    logic [`AXM_TABLE_DEPTH-1:0] loaded_reg;
    logic [POS_W-1:0] feedback_reg;
    logic [2:0] irq_status_reg;
    logic [2:0] irq_mask_reg;
    logic fault_reg;
    logic reached_reg;
    logic busy_last_reg;
    logic [31:0] rdata_reg;
    axm_pkg::axm_mode_type mode_reg;
    axm_pkg::axm_mode_type mode_sel;
    logic wr_ctrl;
    logic ack_pulse;
    logic both_sel;
    logic stop_req;
    logic drive_on;
    logic plus_req;
    logic minus_req;
    logic step_req;
    logic step_take;
    logic step_bad;
    logic step_go;
    logic jog_dir_ok;
    logic jog_go;
    logic jog_bad;
    logic drive_abort;
    logic fault_set;
    logic [7:0] tgt_slot;
    logic [7:0] wr_slot;
    logic [POS_W-1:0] dim_val;
    logic signed [POS_W:0] delta;
    logic [POS_W:0] delta_mag;
    logic [5:0] status_word;
    logic [2:0] irq_event;

    // ==========================================================
    // index to table slot, bit 7 flags a legal index
    function automatic logic [7:0] axm_slot(input logic [7:0] idx);
        logic [7:0] res;
        res = 8'h00;
        if (idx >= `AXM_IDX_FIRST && idx <= `AXM_IDX_LAST)
            res = {1'b1, idx[6:0] - 7'h01};
        else if (idx == `AXM_IDX_SPECIAL_A)
            res = {1'b1, `AXM_SLOT_SPECIAL_A};
        else if (idx == `AXM_IDX_SPECIAL_B)
            res = {1'b1, `AXM_SLOT_SPECIAL_B};
        return res;
    endfunction

    // ==========================================================
    // mode selection from the handler bits
    assign both_sel = ctrl_reg[`AXM_CTRL_STEP_SEL] && ctrl_reg[`AXM_CTRL_MANUAL_SEL];
    always_comb
    begin
        mode_sel = axm_pkg::AXM_MODE_IDLE;
        if (both_sel)
            mode_sel = axm_pkg::AXM_MODE_IDLE; // one mode at a time
        else if (ctrl_reg[`AXM_CTRL_STEP_SEL])
            mode_sel = axm_pkg::AXM_MODE_STEP;
        else if (ctrl_reg[`AXM_CTRL_MANUAL_SEL])
            mode_sel = axm_pkg::AXM_MODE_JOG;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            mode_reg <= axm_pkg::AXM_MODE_IDLE;
        else
            mode_reg <= mode_sel;
    end

    // ==========================================================
    // step command evaluation
    assign stop_req = ctrl_reg[`AXM_CTRL_STOP];
    assign drive_on = ctrl_reg[`AXM_CTRL_DRIVE];
    assign plus_req = ctrl_reg[`AXM_CTRL_PLUS];
    assign minus_req = ctrl_reg[`AXM_CTRL_MINUS];
    assign step_req = ctrl_reg[`AXM_CTRL_START] || plus_req || minus_req;
    assign tgt_slot = axm_slot(target_reg);
    assign dim_val = dim_reg[tgt_slot[6:0]];
    assign delta = $signed({dim_val[POS_W-1], dim_val})
        - $signed({mif.position[POS_W-1], mif.position});
    assign delta_mag = delta[POS_W] ? -delta : delta;
    // fault blocks taking any command
    assign step_take = mode_reg == axm_pkg::AXM_MODE_STEP
        && mode_sel == axm_pkg::AXM_MODE_STEP && step_req
        && !mif.busy && !fault_reg && !stop_req;
    always_comb
    begin
        step_bad = !drive_on || !tgt_slot[7] || !loaded_reg[tgt_slot[6:0]];
        if (!ctrl_reg[`AXM_CTRL_REL])
            step_bad = step_bad || (plus_req && delta[POS_W])
                || (minus_req && !delta[POS_W] && delta != '0);
        if (plus_req && minus_req)
            step_bad = 1'b1;
    end
    assign step_go = step_take && !step_bad;

    // ==========================================================
    // jog command evaluation, directions are held levels
    assign jog_dir_ok = plus_req ^ minus_req;
    assign jog_go = mode_reg == axm_pkg::AXM_MODE_JOG
        && mode_sel == axm_pkg::AXM_MODE_JOG && jog_dir_ok && drive_on
        && !mif.busy && !fault_reg && !stop_req;
    assign jog_bad = mode_reg == axm_pkg::AXM_MODE_JOG && jog_dir_ok
        && !drive_on && !fault_reg && !mif.busy;

    // ==========================================================
    // engine commands
    always_comb
    begin
        mif.go = step_go || jog_go;
        mif.jog = jog_go;
        mif.dir_plus = jog_go ? plus_req : !minus_req;
        mif.distance = dim_val;
        if (step_go && !ctrl_reg[`AXM_CTRL_REL])
        begin
            mif.dir_plus = !delta[POS_W]; // absolute target
            mif.distance = delta_mag[POS_W-1:0];
        end
    end
    // step moves run rapid, jog follows speed_select
    assign mif.rapid = (mode_reg == axm_pkg::AXM_MODE_JOG) ? ctrl_reg[`AXM_CTRL_SPEED] : 1'b1;
    assign drive_abort = mif.busy && !drive_on;
    // abort on stop, drive loss, mode change
    assign mif.halt = mif.busy && (stop_req || !drive_on || mode_sel != mode_reg
        || (mode_reg == axm_pkg::AXM_MODE_JOG && !jog_dir_ok));

    axm_motion #(
        .POS_W(POS_W),
        .CREEP_DIV(CREEP_DIV),
        .RAPID_DIV(RAPID_DIV)
    ) u_motion (
        .clock(clock),
        .rst(rst),
        .mif(mif),
        .step_pulse(motor_step),
        .step_dir(motor_dir)
    );

    assign motor_enable = drive_on;

    // ==========================================================
    // control register, bus write wins over the hardware clear
    assign wr_ctrl = bus_wr && bus_addr == `AXM_ADDR_CTRL;
    assign ack_pulse = wr_ctrl && bus_wdata[`AXM_CTRL_ACK];
    always_ff @(posedge clock)
    begin
        if (rst)
            ctrl_reg <= `AXM_CTRL_RESET;
        else if (wr_ctrl)
            ctrl_reg <= {bus_wdata[10:7], 1'b0, bus_wdata[5:0]};
        else if (step_take)
        begin
            ctrl_reg[`AXM_CTRL_START] <= 1'b0;
            ctrl_reg[`AXM_CTRL_PLUS] <= 1'b0;
            ctrl_reg[`AXM_CTRL_MINUS] <= 1'b0;
        end
    end

    // ==========================================================
    // target index and dimension table
    assign wr_slot = axm_slot(dim_index_reg);
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            target_reg <= 8'h00;
            dim_index_reg <= 8'h00;
            loaded_reg <= '0;
        end
        else if (bus_wr)
        begin
            if (bus_addr == `AXM_ADDR_TARGET)
                target_reg <= bus_wdata[7:0];
            if (bus_addr == `AXM_ADDR_DIM_INDEX)
                dim_index_reg <= bus_wdata[7:0];
            if (bus_addr == `AXM_ADDR_DIM_VALUE && wr_slot[7])
            begin
                dim_reg[wr_slot[6:0]] <= bus_wdata[POS_W-1:0];
                loaded_reg[wr_slot[6:0]] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // fault flag, a new fault wins over the acknowledge
    assign fault_set = both_sel || (step_take && step_bad) || jog_bad || drive_abort;
    always_ff @(posedge clock)
    begin
        if (rst)
            fault_reg <= 1'b0;
        else if (fault_set)
            fault_reg <= 1'b1;
        else if (ack_pulse)
            fault_reg <= 1'b0;
    end

    // ==========================================================
    // target reached flag and feedback position
    always_ff @(posedge clock)
    begin
        if (rst)
            reached_reg <= 1'b0;
        else if (step_go)
            reached_reg <= 1'b0;
        else if (mif.arrived && mode_reg == axm_pkg::AXM_MODE_STEP)
            reached_reg <= 1'b1;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            feedback_reg <= '0;
        else if (mode_sel != axm_pkg::AXM_MODE_IDLE)
            feedback_reg <= mif.position;
    end

    // ==========================================================
    // status word
    always_comb
    begin
        status_word = '0;
        status_word[`AXM_STAT_STEP_ACT] = mode_reg == axm_pkg::AXM_MODE_STEP;
        status_word[`AXM_STAT_MANUAL_ACT] = mode_reg == axm_pkg::AXM_MODE_JOG;
        status_word[`AXM_STAT_MOTION] = mif.busy && mode_reg == axm_pkg::AXM_MODE_STEP;
        status_word[`AXM_STAT_REACHED] = reached_reg;
        status_word[`AXM_STAT_JOG_RUN] = mif.busy && mode_reg == axm_pkg::AXM_MODE_JOG;
        status_word[`AXM_STAT_FAULT] = fault_reg;
    end

    // ==========================================================
    // interrupt status and mask, an event wins over the write-one clear
    assign irq_event = {busy_last_reg && !mif.busy, fault_set,
        mif.arrived && mode_reg == axm_pkg::AXM_MODE_STEP}; // move end, fault, reached
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            busy_last_reg <= 1'b0;
            irq_status_reg <= `AXM_IRQ_RESET;
            irq_mask_reg <= `AXM_IRQ_RESET;
        end
        else
        begin
            busy_last_reg <= mif.busy;
            irq_status_reg <= irq_status_reg | irq_event;
            if (bus_wr && bus_addr == `AXM_ADDR_IRQ_STATUS)
                irq_status_reg <= (irq_status_reg & ~bus_wdata[2:0]) | irq_event;
            if (bus_wr && bus_addr == `AXM_ADDR_IRQ_MASK)
                irq_mask_reg <= bus_wdata[2:0];
        end
    end
    assign irq = |(irq_status_reg & irq_mask_reg);

    // ==========================================================
    // register read, data stand only in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (rst || !bus_rd)
            rdata_reg <= 32'h0000_0000;
        else
            case (bus_addr)
                `AXM_ADDR_CTRL: rdata_reg <= {21'h00000, ctrl_reg};
                `AXM_ADDR_TARGET: rdata_reg <= {24'h000000, target_reg};
                `AXM_ADDR_STATUS: rdata_reg <= {26'h000000, status_word};
                `AXM_ADDR_POSITION: rdata_reg <= 32'(feedback_reg);
                `AXM_ADDR_DIM_INDEX: rdata_reg <= {24'h000000, dim_index_reg};
                `AXM_ADDR_DIM_VALUE: rdata_reg <= 32'(dim_reg[wr_slot[6:0]]);
                `AXM_ADDR_IRQ_STATUS: rdata_reg <= {29'h0000000, irq_status_reg};
                `AXM_ADDR_IRQ_MASK: rdata_reg <= {29'h0000000, irq_mask_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
    end
    assign bus_rdata = rdata_reg;

    // ==========================================================
    // protocol checks
    chk_stop_halts_move: assert property (@(posedge clock) disable iff (rst)
        mif.busy && stop_req |=> !mif.busy) else $error("stop left the move running");
    chk_drive_drop_abort: assert property (@(posedge clock) disable iff (rst)
        mif.busy && !drive_on |=> !mif.busy) else $error("drive loss left the move running");
    chk_motion_on_start: assert property (@(posedge clock) disable iff (rst)
        step_go |=> status_word[`AXM_STAT_MOTION]) else $error("step move showed no motion");
    chk_reached_clear: assert property (@(posedge clock) disable iff (rst)
        step_go |=> !reached_reg) else $error("target reached kept at a new approach");
    chk_start_bits_clear: assert property (@(posedge clock) disable iff (rst)
        step_take && !wr_ctrl |=> !step_req) else $error("start request kept after acceptance");
    chk_fault_on_bad: assert property (@(posedge clock) disable iff (rst)
        step_take && step_bad |=> fault_reg) else $error("refused step command raised no fault");
endmodule
